// file: src/rx_cdr_pkg.sv
package rx_cdr_pkg;

  // Register bus geometry.
  localparam int ADDR_W = 4;
  localparam int REG_W  = 16;

  // Register word indices.
  localparam logic [3:0] OFS_CTRL     = 4'h0;
  localparam logic [3:0] OFS_STATUS   = 4'h1;
  localparam logic [3:0] OFS_THRESH   = 4'h2;
  localparam logic [3:0] OFS_SLIP     = 4'h3;
  localparam logic [3:0] OFS_INT_STAT = 4'h4;
  localparam logic [3:0] OFS_INT_MASK = 4'h5;

  // Control register fields.
  localparam int CTRL_FORCE_REF  = 0;
  localparam int CTRL_FORCE_DATA = 1;
  localparam int CTRL_CFG_LSB    = 2;
  localparam int CTRL_ALIGN_MAN  = 4;
  localparam int CTRL_W          = 5;

  // Status register fields.
  localparam int STAT_LOCKED   = 0;
  localparam int STAT_SIGDET   = 1;
  localparam int STAT_FIFO_ERR = 2;
  localparam int STAT_SLIP_LSB = 4;

  // Interrupt bits, shared by the sticky status and the mask.
  localparam int INT_LOCK_CHG = 0;
  localparam int INT_SIGDET   = 1;
  localparam int INT_FIFO_ERR = 2;
  localparam int INT_W        = 3;

  // Slip command bit.
  localparam int SLIP_GO = 0;

  // Reset values.
  localparam logic [4:0] CTRL_RESET     = 5'h00;
  localparam logic [7:0] THRESH_RESET   = 8'h80;
  localparam logic [2:0] INT_MASK_RESET = 3'h0;

  // Highest bit-slip count of the manual word aligner.
  localparam logic [3:0] SLIP_TOP = 4'h9;

  // Timing: reference lock must hold this long before data tracking.
  localparam int CLK_PERIOD_NS = 50;
  localparam int LOCK_TIME_NS  = 1000;
  localparam int LOCK_CYC      = (LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Channel configurations.
  typedef enum logic [1:0] {
    CFG_BASIC      = 2'h0,
    CFG_BASIC_8B10B = 2'h1,
    CFG_PIPE       = 2'h2,
    gigabit_ethernet_config = 2'h3
  } chan_cfg_t;

  // Clock recovery states, one-hot.
  typedef enum logic [1:0] {
    reference_tracking_state = 2'b01,
    DATA_TRACKING_STATE      = 2'b10
  } cdr_state_t;

endpackage

// file: src/rx_fifo_if.sv
`timescale 1ns/1ps
`default_nettype none

interface rx_fifo_if #(
  parameter int WIDTH = 10
);
  logic             wr_valid;
  logic [WIDTH-1:0] wr_data;
  logic             rd_en;
  logic             rd_valid;
  logic [WIDTH-1:0] rd_data;
  logic             fifo_error;

  modport fifo (
    input  wr_valid,
    input  wr_data,
    input  rd_en,
    output rd_valid,
    output rd_data,
    output fifo_error
  );

  modport core (
    output wr_valid,
    output wr_data,
    output rd_en,
    input  rd_valid,
    input  rd_data,
    input  fifo_error
  );
endinterface

`default_nettype wire

// file: src/rx_phase_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module rx_phase_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  // Clock and synchronised reset.
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // Fill and drain sides.
  rx_fifo_if.fifo   port
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wptr;
  logic [AW-1:0]    rptr;
  logic [CW-1:0]    count;
  logic [CW-1:0]    next_count;
  wire              full  = (count == CW'(DEPTH));
  wire              empty = (count == '0);
  wire              push  = port.wr_valid && !full;
  wire              pop   = port.rd_en && !empty;

  // Occupancy after this edge; the error flag is built from it so it tracks the count.
  assign next_count = count + CW'(push) - CW'(pop);

  // Storage array; a word pushed into a full FIFO is dropped.
  always_ff @(posedge clk_sys)
  begin
    if (push)
      mem[wptr] <= port.wr_data;
  end

  // Pointers, count, registered read data and the full-or-empty flag.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wptr            <= '0;
      rptr            <= '0;
      count           <= '0;
      port.rd_valid   <= 1'b0;
      port.rd_data    <= '0;
      port.fifo_error <= 1'b1;
    end
    else
    begin
      wptr            <= push ? AW'((wptr == AW'(DEPTH - 1)) ? 0 : wptr + 1'b1) : wptr;
      rptr            <= pop ? AW'((rptr == AW'(DEPTH - 1)) ? 0 : rptr + 1'b1) : rptr;
      count           <= next_count;
      port.rd_valid   <= pop;
      port.rd_data    <= pop ? mem[rptr] : port.rd_data;
      port.fifo_error <= (next_count == '0) || (next_count == CW'(DEPTH));
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_fifo_flag: assert property (port.fifo_error == (empty || full))
    else $error("fifo error flag does not match full or empty");
  c_fifo_full: cover property (full);

endmodule

`default_nettype wire

// file: src/rx_cdr_lock_and_status.sv
`timescale 1ns/1ps
`default_nettype none

module rx_cdr_lock_and_status
  import rx_cdr_pkg::*;
#(
  parameter int PAR_W      = 10,
  parameter int FIFO_DEPTH = 8,
  parameter int LEVEL_W    = 8,
  parameter int RECOV_DIV  = 4
) (
  // Clock and reset.
  input  wire logic                    clk_sys,
  input  wire logic                    arst_n,
  // Register port.
  input  wire logic [rx_cdr_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [rx_cdr_pkg::REG_W-1:0]  reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic [rx_cdr_pkg::REG_W-1:0]       reg_rdata,
  // Analog receiver front end, asynchronous pins.
  input  wire logic                    freq_ok_pin,
  input  wire logic [LEVEL_W-1:0]      sig_level_pin,
  // Deserialised words, same clock.
  input  wire logic [PAR_W-1:0]        par_data,
  input  wire logic                    par_valid,
  // Fabric side.
  input  wire logic                    fifo_rd_en,
  output logic [PAR_W-1:0]             rx_data_out,
  output logic                         rx_data_valid,
  output logic                         fifo_error,
  output logic                         freq_locked,
  output logic                         signal_detect,
  output logic [3:0]                   aligner_slip_count,
  output logic                         recov_clk_out,
  output logic                         irq
);
  import rx_cdr_pkg::*;

  localparam int LCW = $clog2(LOCK_CYC + 1);
  localparam int DCW = $clog2(RECOV_DIV + 1);

  // Reset release synchroniser.
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // Pin synchronisers; only the second stage is read by logic.
  logic               freq_ok_meta;
  logic               freq_ok_s;
  logic [LEVEL_W-1:0] level_meta;
  logic [LEVEL_W-1:0] level_s;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      freq_ok_meta <= 1'b0;
      freq_ok_s    <= 1'b0;
      level_meta   <= '0;
      level_s      <= '0;
    end
    else
    begin
      freq_ok_meta <= freq_ok_pin;
      freq_ok_s    <= freq_ok_meta;
      level_meta   <= sig_level_pin;
      level_s      <= level_meta;
    end
  end

  // Software registers.
  logic [CTRL_W-1:0]  ctrl;
  logic [7:0]         thresh;
  logic [INT_W-1:0]   int_stat;
  logic [INT_W-1:0]   int_mask;

  // Address decode.
  wire wr_ctrl   = reg_wr && (reg_addr == OFS_CTRL);
  wire wr_thresh = reg_wr && (reg_addr == OFS_THRESH);
  wire wr_slip   = reg_wr && (reg_addr == OFS_SLIP);
  wire wr_istat  = reg_wr && (reg_addr == OFS_INT_STAT);
  wire wr_imask  = reg_wr && (reg_addr == OFS_INT_MASK);

  // Control fields.
  wire       force_ref  = ctrl[CTRL_FORCE_REF];
  wire       force_data = ctrl[CTRL_FORCE_DATA];
  wire [1:0] cfg        = ctrl[CTRL_CFG_LSB +: 2];
  wire       align_man  = ctrl[CTRL_ALIGN_MAN];
  wire       slip_pulse = wr_slip && reg_wdata[SLIP_GO];
  wire       auto_lock  = !force_data && !force_ref;

  // Configuration gates for the optional outputs.
  wire sigdet_allowed = (cfg == CFG_BASIC_8B10B) || (cfg == CFG_PIPE);
  wire gbe_cfg        = (cfg == gigabit_ethernet_config);

  // Control, threshold and mask registers.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl     <= CTRL_RESET;
      thresh   <= THRESH_RESET;
      int_mask <= INT_MASK_RESET;
    end
    else
    begin
      ctrl     <= wr_ctrl ? reg_wdata[CTRL_W-1:0] : ctrl;
      thresh   <= wr_thresh ? reg_wdata[7:0] : thresh;
      int_mask <= wr_imask ? reg_wdata[INT_W-1:0] : int_mask;
    end
  end

  // Clock recovery lock state machine.
  cdr_state_t     state;
  cdr_state_t     next_state;
  logic [LCW-1:0] lock_cnt;
  logic [LCW-1:0] next_lock_cnt;
  wire            lock_done = (lock_cnt == LCW'(LOCK_CYC - 1));

  // Automatic mode waits for a steady frequency match; forcing overrides it.
  always_comb
  begin
    next_state    = state;
    next_lock_cnt = '0;
    if (force_data)
      next_state = DATA_TRACKING_STATE;
    else if (force_ref)
      next_state = reference_tracking_state;
    else
    begin
      unique case (state)
        reference_tracking_state:
        begin
          if (freq_ok_s && lock_done)
            next_state = DATA_TRACKING_STATE;
          else if (freq_ok_s)
            next_lock_cnt = lock_cnt + 1'b1;
        end
        DATA_TRACKING_STATE:
        begin
          if (!freq_ok_s)
            next_state = reference_tracking_state;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state    <= reference_tracking_state;
      lock_cnt <= '0;
    end
    else
    begin
      state    <= next_state;
      lock_cnt <= next_lock_cnt;
    end
  end

  // Word aligner slip counter; wraps past the last position, idle in automatic alignment.
  logic [3:0] next_slip;

  assign next_slip = !align_man ? 4'h0 :
                     !slip_pulse ? aligner_slip_count :
                     (aligner_slip_count >= SLIP_TOP) ? 4'h0 :
                     aligner_slip_count + 4'h1;

  // Signal detect compare against the programmed threshold.
  wire next_sigdet = sigdet_allowed && (level_s > thresh);

  // Recovered low-speed clock, divided from the system clock while data tracking in the gigabit Ethernet configuration.
  logic [DCW-1:0] div_cnt;
  wire            recov_run = gbe_cfg && (state == DATA_TRACKING_STATE);
  wire            div_wrap  = (div_cnt == DCW'(RECOV_DIV / 2 - 1));

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_cnt       <= '0;
      recov_clk_out <= 1'b0;
    end
    else
    begin
      div_cnt       <= (!recov_run || div_wrap) ? '0 : div_cnt + 1'b1;
      recov_clk_out <= !recov_run ? 1'b0 : (div_wrap ? !recov_clk_out : recov_clk_out);
    end
  end

  // Registered status outputs.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      freq_locked        <= 1'b0;
      signal_detect      <= 1'b0;
      aligner_slip_count <= 4'h0;
    end
    else
    begin
      freq_locked        <= (state == DATA_TRACKING_STATE);
      signal_detect      <= next_sigdet;
      aligner_slip_count <= next_slip;
    end
  end

  // Phase compensation FIFO between the deserialiser and the fabric.
  rx_fifo_if #(.WIDTH(PAR_W)) fifo_bus ();

  assign fifo_bus.wr_valid = par_valid;
  assign fifo_bus.wr_data  = par_data;
  assign fifo_bus.rd_en    = fifo_rd_en;
  assign rx_data_out       = fifo_bus.rd_data;
  assign rx_data_valid     = fifo_bus.rd_valid;
  assign fifo_error        = fifo_bus.fifo_error;

  rx_phase_fifo #(
    .WIDTH (PAR_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .port    (fifo_bus.fifo)
  );

  // Interrupt events; a set in the same cycle as a clear wins.
  logic             locked_d;
  logic             sigdet_d;
  logic             fifo_err_d;
  logic [INT_W-1:0] events;
  logic [INT_W-1:0] clr_bits;

  assign events[INT_LOCK_CHG] = (freq_locked != locked_d);
  assign events[INT_SIGDET]   = signal_detect && !sigdet_d;
  assign events[INT_FIFO_ERR] = fifo_error && !fifo_err_d;
  assign clr_bits             = wr_istat ? reg_wdata[INT_W-1:0] : '0;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      locked_d   <= 1'b0;
      sigdet_d   <= 1'b0;
      fifo_err_d <= 1'b1;
      int_stat   <= '0;
      irq        <= 1'b0;
    end
    else
    begin
      locked_d   <= freq_locked;
      sigdet_d   <= signal_detect;
      fifo_err_d <= fifo_error;
      int_stat   <= (int_stat & ~clr_bits) | events;
      irq        <= |(int_stat & int_mask);
    end
  end

  // Read data selection.
  logic [REG_W-1:0] status_word;
  logic [REG_W-1:0] rd_mux;

  assign status_word = REG_W'({aligner_slip_count, 1'b0, fifo_error, signal_detect, freq_locked});
  assign rd_mux = (reg_addr == OFS_CTRL)     ? REG_W'(ctrl) :
                  (reg_addr == OFS_STATUS)   ? status_word :
                  (reg_addr == OFS_THRESH)   ? REG_W'(thresh) :
                  (reg_addr == OFS_INT_STAT) ? REG_W'(int_stat) :
                  (reg_addr == OFS_INT_MASK) ? REG_W'(int_mask) :
                  '0;

  // Read data stand for the one cycle after the read strobe.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= '0;
    else
      reg_rdata <= reg_rd ? rd_mux : '0;
  end

  // Checks on the lock, slip, detect and clock outputs.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_lock_output: assert property ((state == DATA_TRACKING_STATE) |=> freq_locked)
    else $error("locked output low while data tracking");
  a_ref_unlocked: assert property ((state == reference_tracking_state) |=> !freq_locked)
    else $error("locked output high while reference tracking");
  a_force_data: assert property (force_data |=> (state == DATA_TRACKING_STATE))
    else $error("forced data tracking not taken");
  a_force_ref: assert property (
    (force_ref && !force_data) |=> (state == reference_tracking_state))
    else $error("forced reference tracking not taken");
  a_auto_lock: assert property (
    (auto_lock && state == reference_tracking_state && freq_ok_s && lock_done)
    |=> (state == DATA_TRACKING_STATE))
    else $error("automatic lock did not reach data tracking");
  a_slip_range: assert property (aligner_slip_count <= SLIP_TOP)
    else $error("slip count beyond last position");
  a_slip_step: assert property (
    (align_man && slip_pulse && aligner_slip_count < SLIP_TOP)
    |=> (aligner_slip_count == $past(aligner_slip_count) + 4'h1))
    else $error("slip count did not advance by one");
  a_slip_clear: assert property (!align_man |=> (aligner_slip_count == 4'h0))
    else $error("slip count not cleared in automatic alignment");
  a_sigdet_gate: assert property (!sigdet_allowed |=> !signal_detect)
    else $error("signal detect driven in unsupported configuration");
  a_sigdet_level: assert property ((sigdet_allowed && level_s > thresh) |=> signal_detect)
    else $error("signal detect missed level above threshold");
  a_recov_gate: assert property (!gbe_cfg |=> !recov_clk_out)
    else $error("recovered clock driven outside gigabit configuration");

  c_auto_lock: cover property (auto_lock ##1 (state == DATA_TRACKING_STATE));
  c_slip_wrap: cover property ((aligner_slip_count == SLIP_TOP) ##1 (aligner_slip_count == 4'h0));
  c_sigdet: cover property (signal_detect);
  c_irq: cover property (irq);

endmodule

`default_nettype wire

// file: verification/rx_far_side_model.sv
`timescale 1ns/1ps
`default_nettype none

module rx_far_side_model (
  // Clock.
  input  wire logic       clk_sys,
  // Requests from the bench.
  input  wire logic       push_req,
  input  wire logic [9:0] push_word,
  input  wire logic       ok_req,
  input  wire logic [7:0] level_req,
  // Lock status coming back from the block.
  input  wire logic       freq_locked,
  // Lines into the block and the synchronised status.
  output logic            par_valid,
  output logic [9:0]      par_data,
  output logic            freq_ok_pin,
  output logic [7:0]      sig_level_pin,
  output logic            lock_sync
);
  logic lock_meta;

  // Quiet lines at time zero.
  initial
  begin
    {par_valid, par_data, freq_ok_pin, sig_level_pin, lock_meta, lock_sync} = '0;
  end

  // Words go in one a cycle; between words the data shows the inverse so stale data never matches.
  always @(posedge clk_sys)
  begin
    par_valid     <= push_req;
    par_data      <= push_req ? push_word : ~par_data;
    freq_ok_pin   <= ok_req;
    sig_level_pin <= level_req;
  end

  // The lock status is registered on clk_sys, and it crosses two flops before use.
  always @(posedge clk_sys)
  begin
    lock_meta <= freq_locked;
    lock_sync <= lock_meta;
  end
endmodule

`default_nettype wire

// file: verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import rx_cdr_pkg::*;

  logic clk_sys, arst_n, reg_wr, reg_rd, fifo_rd_en, push_req, ok_req, rd_pend;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, seed, e;
  logic [9:0] push_word, par_data, rx_data_out, w;
  logic [7:0] level_req, sig_level_pin, thr;
  logic par_valid, freq_ok_pin, rx_data_valid, fifo_error, freq_locked, signal_detect;
  logic recov_clk_out, irq, lock_sync, prev;
  logic [3:0] aligner_slip_count;
  logic [1:0] c;
  int n_mismatch, comparisons, n_valid, rises;
  logic [15:0] rd_q[$];
  logic [9:0] data_q[$];

  rx_cdr_lock_and_status i_dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .freq_ok_pin(freq_ok_pin),
    .sig_level_pin(sig_level_pin), .par_data(par_data), .par_valid(par_valid),
    .fifo_rd_en(fifo_rd_en), .rx_data_out(rx_data_out), .rx_data_valid(rx_data_valid),
    .fifo_error(fifo_error), .freq_locked(freq_locked), .signal_detect(signal_detect),
    .aligner_slip_count(aligner_slip_count), .recov_clk_out(recov_clk_out), .irq(irq));

  rx_far_side_model i_far (
    .clk_sys(clk_sys), .push_req(push_req), .push_word(push_word), .ok_req(ok_req),
    .level_req(level_req), .freq_locked(freq_locked), .par_valid(par_valid),
    .par_data(par_data), .freq_ok_pin(freq_ok_pin), .sig_level_pin(sig_level_pin),
    .lock_sync(lock_sync));

  // Clock at 50 ns.
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // Compares one value and counts it.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // Xorshift step for stimulus values.
  function automatic logic [15:0] xs(input logic [15:0] s);
    s = s ^ (s << 7);
    s = s ^ (s >> 9);
    return s ^ (s << 8);
  endfunction

  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // The expected read value is noted first; the monitor compares it.
  task automatic reg_read(input logic [3:0] a, input logic [15:0] x);
    rd_q.push_back(x);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask

  // Monitor: read data and popped words are compared mid-cycle against the oldest note.
  always @(posedge clk_sys) rd_pend <= reg_rd;
  always @(negedge clk_sys)
  begin
    if (rd_pend === 1'b1)
      check(reg_rdata, rd_q.size() ? rd_q.pop_front() : 16'hDEAD);
    if (rx_data_valid === 1'b1)
    begin
      n_valid++;
      check({6'h00, rx_data_out}, {6'h00, data_q.size() ? data_q.pop_front() : 10'h3FF});
    end
  end

  // Watchdog against a hang.
  initial
  begin
    cyc(100000);
    n_mismatch++;
    finish_test();
  end

  initial
  begin
    {reg_wr, reg_rd, fifo_rd_en, push_req, ok_req, rd_pend} = '0;
    {reg_addr, reg_wdata, push_word, level_req} = '0;
    seed = 16'h4EA2;
    arst_n = 1'b0;
    cyc(12);
    check(fifo_error, 1'b1);
    arst_n <= 1'b1;
    cyc(3);
    reg_read(OFS_CTRL, 16'h0000);
    reg_read(OFS_THRESH, 16'h0080);
    reg_read(OFS_INT_MASK, 16'h0000);
    reg_read(4'hF, 16'h0000);
    $display("test reset done");
    // Every force pair, with the frequency match low then high.
    for (int k = 0; k < 8; k++)
    begin
      c = 2'd3 - k[1:0];
      if (c == 2'b00)
      begin
        ok_req <= 1'b0;
        cyc(4);
      end
      ok_req <= k[2];
      reg_write(OFS_CTRL, {14'h0000, c});
      cyc(10);
      if (c == 2'b00 && k[2]) check(freq_locked, 1'b0);
      cyc(22);
      e = {15'h0000, c[1] | (c == 2'b00 & k[2])};
      check(freq_locked, e);
      check(lock_sync, e);
    end
    $display("test lock done");
    // Threshold boundary in every configuration.
    seed = xs(seed);
    thr = {1'b0, seed[6:0]} + 8'h20;
    reg_write(OFS_THRESH, {8'h00, thr});
    reg_read(OFS_THRESH, {8'h00, thr});
    for (int k = 0; k < 8; k++)
    begin
      reg_write(OFS_CTRL, {12'h000, k[2:1], 2'b00});
      level_req <= thr + {7'h00, k[0]};
      cyc(6);
      check(signal_detect, k[0] & (k[2:1] == 2'd1 | k[2:1] == 2'd2));
    end
    $display("test detect done");
    // Sticky event, masked, unmasked and cleared.
    reg_write(OFS_CTRL, 16'h0004);
    level_req <= thr;
    cyc(6);
    reg_write(OFS_INT_STAT, 16'h0007);
    reg_read(OFS_INT_STAT, 16'h0000);
    level_req <= thr + 8'h01;
    cyc(6);
    reg_read(OFS_INT_STAT, 16'h0002);
    check(irq, 1'b0);
    reg_write(OFS_INT_MASK, 16'h0002);
    cyc(3);
    check(irq, 1'b1);
    reg_write(OFS_INT_STAT, 16'h0002);
    cyc(3);
    check(irq, 1'b0);
    reg_read(OFS_INT_MASK, 16'h0002);
    $display("test interrupt done");
    // Fill to full, one refused word, then drain past empty.
    for (int k = 0; k < 9; k++)
    begin
      seed = xs(seed);
      w = seed[9:0];
      if (k < 8) data_q.push_back(w);
      @(posedge clk_sys);
      push_req <= 1'b1;
      push_word <= w;
      @(posedge clk_sys);
      push_req <= 1'b0;
      cyc(3);
      if (k == 6) check(fifo_error, 1'b0);
      if (k == 7) check(fifo_error, 1'b1);
    end
    n_valid = 0;
    fifo_rd_en <= 1'b1;
    cyc(9);
    fifo_rd_en <= 1'b0;
    for (int k = 0; k < 20 && data_q.size() > 0; k++) cyc(1);
    cyc(3);
    check(n_valid[15:0], 16'd8);
    check(fifo_error, 1'b1);
    reg_read(OFS_STATUS, 16'h0007);
    reg_read(OFS_INT_STAT, 16'h0004);
    $display("test fifo done");
    // Slip count wraps from nine to zero and clears outside manual mode.
    reg_write(OFS_CTRL, 16'h0010);
    for (int k = 1; k <= 10; k++)
    begin
      reg_write(OFS_SLIP, 16'h0001);
      cyc(2);
      check(aligner_slip_count, 16'(k % 10));
      if (k == 5) reg_read(OFS_STATUS, 16'h0055);
    end
    reg_read(OFS_SLIP, 16'h0000);
    reg_write(OFS_CTRL, 16'h0000);
    cyc(2);
    check(aligner_slip_count, 4'h0);
    $display("test slip done");
    // Recovered clock runs only in the Ethernet configuration.
    for (int k = 0; k < 2; k++)
    begin
      reg_write(OFS_CTRL, k ? 16'h0002 : 16'h000E);
      cyc(5);
      rises = 0;
      prev = recov_clk_out;
      repeat (40)
      begin
        @(negedge clk_sys);
        if (recov_clk_out === 1'b1 && prev === 1'b0) rises++;
        prev = recov_clk_out;
      end
      check(k ? rises == 0 : (rises >= 9 && rises <= 11), 1'b1);
    end
    $display("test recovered clock done");
    cyc(4);
    check(rd_q.size(), 16'd0);
    finish_test();
  end
endmodule

`default_nettype wire
